/* rtl/fcs_consts.svh */
/*
  Offsets, field positions, reset values and limits of the flash command
  status block. Included by the package user; holds definitions only.
*/
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// Register indices; the byte address is four times the index
`define FCS_IDX_CMD_INDEX  3'h0
`define FCS_IDX_CMD_WORD   3'h1
`define FCS_IDX_EEP_PROT   3'h2
`define FCS_IDX_CMD_STATUS 3'h6
`define FCS_IDX_ERR_STATUS 3'h7

// Command status field positions
`define FCS_COMMAND_COMPLETE_FLAG_BIT   7
`define FCS_ACCESS_ERROR_FLAG_BIT 5
`define FCS_PROTECTION_VIOLATION_FLAG_BIT 4
`define FCS_BUSY_BIT   3
`define FCS_RSVD_BIT   2

// Error status field positions
`define FCS_ERR_UNCORR_BIT 1
`define FCS_ERR_CORR_BIT   0

// Protection register: enable bit, size field is [5:0] in 32-byte units
`define FCS_EPROT_EN_BIT 7

// Reset values
`define FCS_RST_EEP_PROT  8'h00
`define FCS_RST_CMD_INDEX 3'h0

// Program-EEPROM command code and legal last command word index
`define FCS_CMD_PGM_EEP 8'h01
`define FCS_IDX_MIN     3'h2
`define FCS_IDX_MAX     3'h5

// EEPROM block global address range
`define FCS_EEP_BASE 18'h00400
`define FCS_EEP_END  18'h013ff

// Nonvolatile configuration field layout
`define FCS_CFG_KEY_BASE 18'h3ff00
`define FCS_CFG_KEY_LEN  8
`define FCS_CFG_PHRASE   18'h3ff08
`define FCS_CFG_PROGRAM_FLASH_PROTECTION    18'h3ff0c
`define FCS_CFG_EEPROM_PROTECTION   18'h3ff0d
`define FCS_CFG_NVOPT    18'h3ff0e
`define FCS_CFG_SEC      18'h3ff0f

// Bus answers
`define FCS_RESP_OKAY   2'h0
`define FCS_RESP_SLVERR 2'h2

`endif

/* rtl/fcs_pkg.sv */
/*
  Types of the flash command status block: bus carriers, array carriers,
  sequencer states and the block's state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcs_pkg;

  typedef enum logic [1:0] {
    FCS_IDLE  = 2'b00,
    FCS_CHECK = 2'b01,
    FCS_RUN   = 2'b10
  } fcs_state_e_t;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } fcs_axi_req_t;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fcs_axi_rsp_t;

  // Program order toward the array
  typedef struct packed {
    logic             start;
    logic [17:0]      addr;
    logic [2:0]       nwords;
    logic [3:0][15:0] data;
  } fcs_arr_cmd_t;

  // Reports from the array
  typedef struct packed {
    logic       done;
    logic       verify_err;
    logic       verify_fatal;
    logic       init_valid;
    logic [1:0] init_status;
    logic       fault_corr;
    logic       fault_uncorr;
  } fcs_arr_rsp_t;

  typedef struct packed {
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    fcs_axi_rsp_t     bus;
    fcs_state_e_t     st;
    logic             command_complete_flag;
    logic             access_error_flag;
    logic             protection_violation_flag;
    logic [1:0]       mgstat;
    logic [1:0]       ferr;
    logic [2:0]       idx;
    logic [5:0][15:0] words;
    logic [7:0]       eprot;
    fcs_arr_cmd_t     arr;
  } fcs_regs_t;

endpackage

/* rtl/fcs_flash_status.sv */
/*
  Command launch, status flags and program-EEPROM launch checks of a
  flash memory controller, with an AXI4-Lite register slave.
  Assumes the array reports done as a one-cycle pulse after each start,
  and that all inputs except the asynchronous reset arst_n are synchronous to clk.
*/
// Summary of operation
// - Writing one to command-complete launches; it stays low until finish or rejection.
// - Sequence violations and illegal commands set access error; it blocks launches.
// - Access error clears only on a written one; zero leaves it.
// - Protection violation set on protected program; written one clears it.
// - While protection violation is set, no launch and no new command sequence.
// - Busy reads one while a command executes, zero when idle.
// - Status bit 2 always reads zero.
// - Completion status bits set on execution or reset-sequence errors.
// - Error status flags are readable and only clearable by writes.
// - Configuration field holds an eight-byte backdoor key at its base.
// - Configuration field holds protection, option and security bytes at fixed places.
// - Program-EEPROM launch with index below two or above five is an access error.
// - Program-EEPROM launch in a mode lacking the command is an access error.
// - Program-EEPROM with an invalid global address is an access error.
// - Program-EEPROM with an odd word address is an access error.
// - Program-EEPROM running past the EEPROM end is an access error.
// - Program-EEPROM into a protected area is a protection violation.
// - Verify errors set the upper status bit, uncorrectable ones the lower.
`timescale 1ns/1ps
`include "fcs_consts.svh"

module fcs_flash_status
  import fcs_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire fcs_axi_req_t axi_req,
  output fcs_axi_rsp_t      axi_rsp,
  input  wire logic         pgm_eep_allowed,
  output fcs_arr_cmd_t      arr_cmd,
  input  wire fcs_arr_rsp_t arr_rsp
);

  // Whole state of the block; d is what it becomes at the next edge
  fcs_regs_t q;
  fcs_regs_t d;

  // Combinational helpers
  logic        wr_now;
  logic        wr_hit;
  logic        rd_hit;
  logic [2:0]  wr_idx;
  logic [2:0]  rd_idx;
  logic [7:0]  wr_byte0;
  logic        launch;
  logic        set_acc;
  logic        set_vio;
  logic        clr_acc;
  logic        clr_vio;
  logic [1:0]  clr_ferr;
  logic [7:0]  cmd_code;
  logic [17:0] g_addr;
  logic [2:0]  n_words;
  logic [17:0] last_addr;
  logic [17:0] prot_lo;
  logic        chk_acc;
  logic        chk_vio;
  logic [31:0] rd_val;

  // One when the address hits a mapped register, zero for any other address
  function automatic logic reg_hit(input logic [7:0] a);
    logic [2:0] i;
    i = a[4:2];
    reg_hit = (a[7:5] == 3'h0) &&
              (i == `FCS_IDX_CMD_INDEX || i == `FCS_IDX_CMD_WORD ||
               i == `FCS_IDX_EEP_PROT || i == `FCS_IDX_CMD_STATUS ||
               i == `FCS_IDX_ERR_STATUS);
  endfunction

  // Address lies inside the EEPROM block
  // Both bounds are inclusive, so the last byte is still a legal target
  function automatic logic in_eep(input logic [17:0] a);
    in_eep = (a >= `FCS_EEP_BASE) && (a <= `FCS_EEP_END);
  endfunction

  // Role of a global address inside the nonvolatile configuration field:
  // 0 outside, 1 backdoor key, 2 reserved, 3 program-flash protection,
  // 4 EEPROM protection, 5 option byte, 6 security byte
  function automatic logic [2:0] cfg_slot(input logic [17:0] a);
    logic [17:0] off;
    off = a - `FCS_CFG_KEY_BASE;
    if (a < `FCS_CFG_KEY_BASE || a > `FCS_CFG_SEC) begin
      cfg_slot = 3'h0;
    end else if (off < 18'(`FCS_CFG_KEY_LEN)) begin
      cfg_slot = 3'h1;
    end else if (a < `FCS_CFG_PROGRAM_FLASH_PROTECTION) begin
      cfg_slot = 3'h2;
    end else if (a == `FCS_CFG_PROGRAM_FLASH_PROTECTION) begin
      cfg_slot = 3'h3;
    end else if (a == `FCS_CFG_EEPROM_PROTECTION) begin
      cfg_slot = 3'h4;
    end else if (a == `FCS_CFG_NVOPT) begin
      cfg_slot = 3'h5;
    end else begin
      cfg_slot = 3'h6;
    end
  endfunction

  // Write data bytes gated by their strobes
  // Only the low half of the bus carries a sixteen-bit command word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
    merge16 = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Command parameters decoded from the stored command words; the word
  // count is one less than the last index, prot_lo is the first
  // protected byte of the EEPROM
  always_comb begin
    cmd_code  = q.words[0][15:8];
    g_addr    = {q.words[0][1:0], q.words[1]};
    n_words   = q.idx - 3'h1;
    last_addr = g_addr + {14'h0000, n_words, 1'b0} - 18'h00001;
    prot_lo   = `FCS_EEP_END - {7'h00, q.eprot[5:0], 5'h1f};
    chk_acc   = 1'b0;
    chk_vio   = 1'b0;
    if (cmd_code != `FCS_CMD_PGM_EEP) begin
      chk_acc = 1'b1;
    end
    if (q.idx < `FCS_IDX_MIN || q.idx > `FCS_IDX_MAX) begin
      chk_acc = 1'b1;
    end
    if (!pgm_eep_allowed) begin
      chk_acc = 1'b1;
    end
    if (!in_eep(g_addr)) begin
      chk_acc = 1'b1;
    end
    if (g_addr[0]) begin
      chk_acc = 1'b1;
    end
    if (!in_eep(last_addr) || last_addr < g_addr) begin
      chk_acc = 1'b1;
    end
    // The configuration field belongs to the program flash, so an EEPROM
    // program may never reach it, even if the EEPROM window is moved
    if (cfg_slot(g_addr) != 3'h0 || cfg_slot(last_addr) != 3'h0) begin
      chk_acc = 1'b1;
    end
    // Protection only matters once the request itself is well formed
    if (!chk_acc && q.eprot[`FCS_EPROT_EN_BIT] && last_addr >= prot_lo) begin
      chk_vio = 1'b1;
    end
  end

  // Read data of the register addressed by the read channel
  // Command word indices six and seven have no storage and read zero
  always_comb begin
    rd_hit = reg_hit(axi_req.araddr);
    rd_idx = axi_req.araddr[4:2];
    rd_val = 32'h0000_0000;
    unique case (rd_idx)
      `FCS_IDX_CMD_INDEX:  rd_val[2:0] = q.idx;
      `FCS_IDX_CMD_WORD:   rd_val[15:0] = (q.idx <= 3'h5) ? q.words[q.idx] : 16'h0000;
      `FCS_IDX_EEP_PROT:   rd_val[7:0] = q.eprot;
      `FCS_IDX_CMD_STATUS: begin
        rd_val[`FCS_COMMAND_COMPLETE_FLAG_BIT]   = q.command_complete_flag;
        rd_val[`FCS_ACCESS_ERROR_FLAG_BIT] = q.access_error_flag;
        rd_val[`FCS_PROTECTION_VIOLATION_FLAG_BIT] = q.protection_violation_flag;
        rd_val[`FCS_BUSY_BIT]   = !q.command_complete_flag;
        rd_val[`FCS_RSVD_BIT]   = 1'b0;
        rd_val[1:0]             = q.mgstat;
      end
      `FCS_IDX_ERR_STATUS: rd_val[1:0] = q.ferr;
      default:             rd_val = 32'h0000_0000;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    d             = q;
    d.arr.start   = 1'b0;
    wr_now        = q.aw_got && q.w_got && !q.bus.bvalid;
    wr_hit        = reg_hit(q.aw_addr);
    wr_idx        = q.aw_addr[4:2];
    wr_byte0      = q.w_strb[0] ? q.w_data[7:0] : 8'h00;
    launch        = 1'b0;
    set_acc       = 1'b0;
    set_vio       = 1'b0;
    clr_acc       = 1'b0;
    clr_vio       = 1'b0;
    clr_ferr      = 2'b00;

    // Write address and data are taken independently, in either order
    if (axi_req.awvalid && q.bus.awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.bus.wready) begin
      d.w_got  = 1'b1;
      d.w_data = axi_req.wdata;
      d.w_strb = axi_req.wstrb;
    end
    if (q.bus.bvalid && axi_req.bready) begin
      d.bus.bvalid = 1'b0;
    end

    // Register write once both halves are held
    // Refused sequence writes still answer OKAY; the flags tell software why
    if (wr_now) begin
      d.aw_got     = 1'b0;
      d.w_got      = 1'b0;
      d.bus.bvalid = 1'b1;
      d.bus.bresp  = wr_hit ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
      if (wr_hit) begin
        unique case (wr_idx)
          `FCS_IDX_CMD_INDEX: begin
            // A blocked sequence start is silently dropped
            if (q.protection_violation_flag) begin
            end else if (!q.command_complete_flag) begin
              set_acc = 1'b1;
            end else if (q.w_strb[0]) begin
              d.idx = q.w_data[2:0];
            end
          end
          `FCS_IDX_CMD_WORD: begin
            if (q.protection_violation_flag) begin
            end else if (!q.command_complete_flag || q.idx > 3'h5) begin
              set_acc = 1'b1;
            end else begin
              d.words[q.idx] = merge16(q.words[q.idx], q.w_data, q.w_strb);
            end
          end
          `FCS_IDX_EEP_PROT: begin
            if (q.w_strb[0]) begin
              d.eprot = q.w_data[7:0];
            end
          end
          `FCS_IDX_CMD_STATUS: begin
            clr_acc = wr_byte0[`FCS_ACCESS_ERROR_FLAG_BIT];
            clr_vio = wr_byte0[`FCS_PROTECTION_VIOLATION_FLAG_BIT];
            // Flags seen before this write gate the launch
            launch  = wr_byte0[`FCS_COMMAND_COMPLETE_FLAG_BIT] && q.command_complete_flag &&
                      !q.access_error_flag && !q.protection_violation_flag;
          end
          `FCS_IDX_ERR_STATUS: begin
            clr_ferr = wr_byte0[1:0];
          end
          default: begin
          end
        endcase
      end
    end

    // Sequencer
    unique case (q.st)
      FCS_IDLE: begin
        // Waits for a launch write that no flag blocks
        if (launch) begin
          d.command_complete_flag   = 1'b0;
          d.mgstat = 2'b00;
          d.st     = FCS_CHECK;
        end
      end
      FCS_CHECK: begin
        // One cycle of checks; a refusal never reaches the array
        if (chk_acc || chk_vio) begin
          set_acc = set_acc | chk_acc;
          set_vio = chk_vio;
          d.command_complete_flag  = 1'b1;
          d.st    = FCS_IDLE;
        end else begin
          d.arr.start  = 1'b1;
          d.arr.addr   = g_addr;
          d.arr.nwords = n_words;
          d.arr.data   = {q.words[5], q.words[4], q.words[3], q.words[2]};
          d.st         = FCS_RUN;
        end
      end
      FCS_RUN: begin
        // The array owns the command until its done pulse
        if (arr_rsp.done) begin
          d.mgstat = {arr_rsp.verify_err, arr_rsp.verify_fatal};
          d.command_complete_flag   = 1'b1;
          d.st     = FCS_IDLE;
        end
      end
      default: begin
        d.st   = FCS_IDLE;
        d.command_complete_flag = 1'b1;
      end
    endcase

    // Reset-sequence errors add to the completion status
    if (arr_rsp.init_valid) begin
      d.mgstat = d.mgstat | arr_rsp.init_status;
    end

    // Sticky flags: a set in the clearing cycle wins
    // Letting the clear win would silently lose an error seen in that cycle
    d.access_error_flag = (q.access_error_flag & !clr_acc) | set_acc;
    d.protection_violation_flag = (q.protection_violation_flag & !clr_vio) | set_vio;
    d.ferr   = (q.ferr & ~clr_ferr) |
               {arr_rsp.fault_uncorr, arr_rsp.fault_corr};

    // Read channel: one read at a time, answered the cycle after it is taken
    if (q.bus.rvalid && axi_req.rready) begin
      d.bus.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.bus.arready) begin
      d.bus.rvalid = 1'b1;
      d.bus.rdata  = rd_hit ? rd_val : 32'h0000_0000;
      d.bus.rresp  = rd_hit ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
    end

    // Readies are registered so every port comes from a flop
    // Low ready while a response waits keeps one write and one read in flight
    d.bus.awready = !d.aw_got && !d.bus.bvalid;
    d.bus.wready  = !d.w_got && !d.bus.bvalid;
    d.bus.arready = !d.bus.rvalid;
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Readies start high so a master may offer at the first edge, and
      // complete starts high because no command is under way
      q             <= '0;
      q.bus.awready <= 1'b1;
      q.bus.wready  <= 1'b1;
      q.bus.arready <= 1'b1;
      q.st          <= FCS_IDLE;
      q.command_complete_flag        <= 1'b1;
      q.idx         <= `FCS_RST_CMD_INDEX;
      q.eprot       <= `FCS_RST_EEP_PROT;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign axi_rsp = q.bus;
  assign arr_cmd = q.arr;

endmodule

/* verif/fcs_flash_status_chk.sv */
/*
  Port-level checker of the flash command status block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_flash_status_chk
  import fcs_pkg::*;
(
  input wire logic         clk,
  input wire logic         arst_n,
  input wire fcs_axi_req_t axi_req,
  input wire fcs_axi_rsp_t axi_rsp,
  input wire logic         pgm_eep_allowed,
  input wire fcs_arr_cmd_t arr_cmd,
  input wire fcs_arr_rsp_t arr_rsp
);
  logic [7:0]  rd_addr_q;
  logic        st_rd;
  logic [18:0] last_byte;

  // Remember the read address so the answer can be decoded
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_addr_q <= 8'h00;
    end else if (axi_req.arvalid && axi_rsp.arready) begin
      rd_addr_q <= axi_req.araddr;
    end
  end

  // Status read and last byte of the program group
  assign st_rd     = axi_rsp.rvalid && (rd_addr_q == 8'h18);
  assign last_byte = {1'b0, arr_cmd.addr} + {15'h0, arr_cmd.nwords, 1'b0} - 19'h1;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_quiet;
    !arr_cmd.start [*2];
  endsequence
  sequence s_launch;
    $past(axi_rsp.bvalid) && arr_cmd.start;
  endsequence

  property p_start_pulse;
    arr_cmd.start |=> s_quiet;
  endproperty
  property p_start_after_write;
    arr_cmd.start |-> s_launch;
  endproperty
  property p_start_mode;
    arr_cmd.start |-> $past(pgm_eep_allowed);
  endproperty
  property p_start_align;
    arr_cmd.start |-> !arr_cmd.addr[0];
  endproperty
  property p_start_range;
    arr_cmd.start |-> arr_cmd.addr >= `FCS_EEP_BASE && last_byte <= {1'b0, `FCS_EEP_END};
  endproperty
  property p_start_words;
    arr_cmd.start |-> arr_cmd.nwords != 3'h0 && arr_cmd.nwords <= 3'h4;
  endproperty
  property p_busy_mirror;
    st_rd |-> axi_rsp.rdata[3] == !axi_rsp.rdata[7];
  endproperty
  property p_rsvd_zero;
    st_rd |-> !axi_rsp.rdata[2];
  endproperty

  a_start_pulse:       assert property (p_start_pulse)
    else $error("array start longer than one cycle");
  a_start_after_write: assert property (p_start_after_write)
    else $error("array start without launch write");
  a_start_mode:        assert property (p_start_mode)
    else $error("array start in mode without command");
  a_start_align:       assert property (p_start_align)
    else $error("array start on odd address");
  a_start_range:       assert property (p_start_range)
    else $error("array start outside eeprom block");
  a_start_words:       assert property (p_start_words)
    else $error("array start with bad word count");
  a_busy_mirror:       assert property (p_busy_mirror)
    else $error("busy does not mirror complete");
  a_rsvd_zero:         assert property (p_rsvd_zero)
    else $error("reserved status bit set");
endmodule

/* verif/testbench.sv */
/*
  Self-checking bench of the flash command status block.
  Assumes the bench plays bus master and flash array itself.
*/
`timescale 1ns/1ps
`include "fcs_consts.svh"
module testbench
  import fcs_pkg::*;
;
  logic         clk;
  logic         arst_n;
  logic         pgm_eep_allowed;
  fcs_axi_req_t rq;
  fcs_axi_rsp_t rs;
  fcs_arr_cmd_t ac;
  fcs_arr_rsp_t ar;
  int           n_errors;
  int           n_checks;
  logic [15:0]  seed;
  logic [1:0]   resp;
  logic [1:0]   ms;
  logic [7:0]   prot;
  logic [3:0]   wsb;

  fcs_flash_status fcs_flash_status_inst (
    .clk            (clk),
    .arst_n         (arst_n),
    .axi_req        (rq),
    .axi_rsp        (rs),
    .pgm_eep_allowed(pgm_eep_allowed),
    .arr_cmd        (ac),
    .arr_rsp        (ar)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Expected status byte
  function automatic logic [31:0] st(input logic cc, ae, pv, input logic [1:0] m);
    return {24'h0, cc, 1'b0, ae, pv, ~cc, 1'b0, m};
  endfunction

  // Expected {access error, protection violation} of one launch
  function automatic logic [1:0] expe(input logic [7:0] c, input logic [17:0] a,
                                      input logic [2:0] ix, input logic en);
    logic [18:0] lb;
    logic [18:0] ps;
    logic        ae;
    lb = {1'b0, a} + 19'({ix - 3'h1, 1'b0}) - 19'h1;
    ps = 19'(`FCS_EEP_END) + 19'h1 - 19'({prot[5:0] + 7'h1, 5'h0});
    ae = c != `FCS_CMD_PGM_EEP || ix < `FCS_IDX_MIN || ix > `FCS_IDX_MAX || !en || a[0]
         || a < `FCS_EEP_BASE || lb > 19'(`FCS_EEP_END);
    return {ae, !ae && prot[7] && lb >= ps};
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bus write; address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    rq.awvalid <= 1'b1;
    rq.awaddr  <= a;
    rq.wvalid  <= 1'b1;
    rq.wdata   <= d;
    rq.wstrb   <= wsb;
    rq.bready  <= 1'b1;
    do begin
      @(negedge clk);
      aw   = rs.awready;
      w    = rs.wready;
      b    = rs.bvalid;
      resp = rs.bresp;
      @(posedge clk);
      if (aw) rq.awvalid <= 1'b0;
      if (w) rq.wvalid <= 1'b0;
    end while (!b);
    rq.bready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic        arr, v;
    logic [31:0] d;
    @(posedge clk);
    rq.arvalid <= 1'b1;
    rq.araddr  <= a;
    rq.rready  <= 1'b1;
    do begin
      @(negedge clk);
      arr  = rs.arready;
      v    = rs.rvalid;
      d    = rs.rdata;
      resp = rs.rresp;
      @(posedge clk);
      if (arr) rq.arvalid <= 1'b0;
    end while (!v);
    rq.rready <= 1'b0;
    chk("rdata", d, e);
  endtask

  // Load command words, launch, then answer as the array or check the refusal
  task automatic lau(input logic [7:0] c, input logic [17:0] a, input logic [2:0] ix,
                     input logic en);
    logic [1:0]       e, v;
    logic [15:0]      wv;
    logic [3:0][15:0] dw;
    int               t;
    e = expe(c, a, ix, en);
    v = seed[1:0];
    @(posedge clk);
    pgm_eep_allowed <= en;
    for (int i = 0; i <= int'(ix); i++) begin
      wr(8'h00, 32'(i));
      wv = (a == `FCS_CFG_PHRASE && i < 4) ? 16'hffff : seed;
      if (i >= 2 && i <= 5) dw[i-2] = wv;
      wr(8'h04, i == 0 ? {16'h0, c, 6'h0, a[17:16]} : i == 1 ? {16'h0, a[15:0]} : {16'h0, wv});
      seed = nx(seed);
    end
    wr(8'h18, 32'h80);
    chk("bresp", 32'(resp), 32'(`FCS_RESP_OKAY));
    if (e == 2'b00) begin
      t = 0;
      while (!ac.start && t < 20) begin
        @(negedge clk);
        t++;
      end
      chk("start", 32'(ac.start), 32'h1);
      chk("addr", 32'(ac.addr), 32'(a));
      chk("nwords", 32'(ac.nwords), 32'(ix - 3'h1));
      for (int j = 0; j < int'(ix) - 1; j++) begin
        chk("data", 32'(ac.data[j]), 32'(dw[j]));
      end
      rc(8'h18, st(1'b0, 1'b0, 1'b0, 2'b00));
      wr(8'h00, 32'h0);
      rc(8'h00, 32'(ix));
      @(posedge clk);
      ar.done         <= 1'b1;
      ar.verify_err   <= v[1];
      ar.verify_fatal <= v[0];
      @(posedge clk);
      ar.done <= 1'b0;
      ms = v;
      rc(8'h18, st(1'b1, 1'b1, 1'b0, ms));
      wr(8'h18, 32'h20);
      rc(8'h18, st(1'b1, 1'b0, 1'b0, ms));
    end else begin
      if (ix <= `FCS_IDX_MAX) ms = 2'b00;
      rc(8'h18, st(1'b1, e[1], e[0], ms));
      wr(8'h18, 32'h00);
      rc(8'h18, st(1'b1, e[1], e[0], ms));
      if (e[0]) begin
        wr(8'h00, 32'h1);
        rc(8'h00, 32'(ix));
      end
      wr(8'h18, 32'h80);
      rc(8'h18, st(1'b1, e[1], e[0], ms));
      wr(8'h18, 32'h30);
      rc(8'h18, st(1'b1, 1'b0, 1'b0, ms));
    end
    $display("test launch %h done", a);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog well beyond the few thousand cycles of the run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    rq = '0;
    ar = '0;
    pgm_eep_allowed = 1'b1;
    arst_n = 1'b0;
    n_errors = 0;
    n_checks = 0;
    seed = 16'h0048;
    ms = 2'b00;
    prot = 8'h81;
    wsb = 4'hf;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rc(8'h18, st(1'b1, 1'b0, 1'b0, 2'b00));
    rc(8'h1c, 32'h0);
    rc(8'h0c, 32'h0);
    chk("rresp", 32'(resp), 32'(`FCS_RESP_SLVERR));
    wr(8'h14, 32'h1);
    chk("bresp", 32'(resp), 32'(`FCS_RESP_SLVERR));
    // Reset-sequence error and error-status flags
    @(posedge clk);
    ar.init_valid  <= 1'b1;
    ar.init_status <= 2'b10;
    ar.fault_corr  <= 1'b1;
    ar.fault_uncorr <= 1'b1;
    @(posedge clk);
    ar <= '0;
    ms = 2'b10;
    rc(8'h18, st(1'b1, 1'b0, 1'b0, ms));
    wr(8'h1c, 32'h0);
    rc(8'h1c, 32'h3);
    wr(8'h1c, 32'h1);
    rc(8'h1c, 32'h2);
    wr(8'h1c, 32'h2);
    wr(8'h1c, 32'h3);
    rc(8'h1c, 32'h0);
    wr(8'h08, 32'(prot));
    rc(8'h08, 32'(prot));
    // Partial strobe touches only the low byte of the command word
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h0000_a55a);
    wsb = 4'h1;
    wr(8'h04, 32'h0000_00ff);
    wsb = 4'hf;
    rc(8'h04, 32'h0000_a5ff);
    chk("rresp", 32'(resp), 32'(`FCS_RESP_OKAY));
    $display("test registers done");
    // Corner launches: boundaries, bad index, mode, code, alignment, end, protection
    lau(8'h01, 18'h00400, 3'h2, 1'b1);
    lau(8'h01, 18'h00400, 3'h1, 1'b1);
    lau(8'h01, 18'h00400, 3'h6, 1'b1);
    lau(8'h01, 18'h00400, 3'h5, 1'b0);
    lau(8'h02, 18'h00400, 3'h2, 1'b1);
    lau(8'h01, 18'h00401, 3'h2, 1'b1);
    lau(8'h01, 18'h013fe, 3'h3, 1'b1);
    lau(8'h01, 18'h013be, 3'h3, 1'b1);
    lau(8'h01, 18'h003fe, 3'h2, 1'b1);
    lau(8'h01, `FCS_CFG_PHRASE, 3'h5, 1'b1);
    for (int k = 0; k < 16; k++) begin
      seed = nx(seed);
      lau(&seed[11:9] ? 8'h02 : 8'h01, 18'h00400 + 18'({seed[11:1], seed[14] & seed[15]}),
          (seed[5] & seed[6]) ? seed[2:0] : 3'h2 + 3'(seed[4:3]), seed[7] | seed[8]);
    end
    end_of_test();
  end
endmodule

bind fcs_flash_status fcs_flash_status_chk fcs_flash_status_chk_inst (
  .clk            (clk),
  .arst_n         (arst_n),
  .axi_req        (axi_req),
  .axi_rsp        (axi_rsp),
  .pgm_eep_allowed(pgm_eep_allowed),
  .arr_cmd        (arr_cmd),
  .arr_rsp        (arr_rsp)
);
